//--- core/ibcs_map.svh
// Purpose: constants of the instruction bus cycle sequencer
// Assumes: included by bare name
// Notes:   definitions only
`ifndef IBCS_MAP_SVH
`define IBCS_MAP_SVH

// =============================================================
// sequencing limits
`define IBCS_ADDR_W      24
`define IBCS_MAX_EXT     3'h4
`define IBCS_INT_STATES  2'h1
`define IBCS_IDX_W       3

`endif

//--- core/ibcs_pkg.sv
// Purpose: types of the instruction bus cycle sequencer
// Assumes: ibcs_map.svh supplies the widths
// Notes:   no numbers beyond the header
`include "ibcs_map.svh"

package ibcs_pkg;

	// =============================================================
	// instruction classes
	typedef enum logic [2:0] {
		IBCS_CLS_PLAIN,
		IBCS_CLS_BR_D8,
		IBCS_CLS_BR_D16,
		IBCS_CLS_BIT_TEST,
		IBCS_CLS_BIT_MOD
	} ibcs_cls_t;

	// =============================================================
	// sequencer states
	typedef enum logic [2:0] {
		IBCS_S_IDLE,
		IBCS_S_EXT,
		IBCS_S_EA_RD,
		IBCS_S_NEXT_RD,
		IBCS_S_INTERNAL,
		IBCS_S_TGT_RD,
		IBCS_S_EA_WR
	} ibcs_st_t;

	// =============================================================
	// whole state of the sequencer
	typedef struct packed {
		ibcs_st_t                   st;
		ibcs_cls_t                  cls;
		logic [`IBCS_IDX_W-1:0]     idx;
		logic [`IBCS_IDX_W-1:0]     ext;
		logic [1:0]                 cnt;
		logic [`IBCS_ADDR_W-1:0]    pc;
		logic [`IBCS_ADDR_W-1:0]    ea;
		logic [`IBCS_ADDR_W-1:0]    tgt;
		logic [`IBCS_ADDR_W-1:0]    addr;
		logic                       req;
		logic                       wr;
		logic                       word;
		logic                       lock;
		logic                       internal;
		logic                       busy;
		logic                       done;
	} ibcs_state_t;

endpackage

//--- core/ibcs_addr_gen.sv
// Purpose: word address of the n-th word of an instruction
// Assumes: instruction words are 2 bytes and contiguous
// Notes:   combinational, index 0 is the opcode word
`timescale 1ns/1ps
`default_nettype none

module ibcs_addr_gen #(
	parameter int AW = 24,
	parameter int IW = 3
) (
	input  wire logic [AW-1:0] base_i,
	input  wire logic [IW-1:0] word_idx_i,
	output logic      [AW-1:0] addr_o
);

	// =============================================================
	// consecutive word addresses
	always_comb begin
		addr_o = AW'(base_i + {{(AW-IW-1){1'b0}}, word_idx_i, 1'b0});
	end

endmodule // ibcs_addr_gen

`default_nettype wire

//--- core/ibcs_seq.sv
// Purpose: issues the bus cycles of one instruction in order
// Assumes: bus controller acknowledges each cycle with a one-clock ack pulse, after any number of wait clocks
// Notes:   one clock cycle stands for one state
//
// How it works
// - a cycle flagged locked keeps the bus with the next cycle of the same instruction or, when it is the last cycle, up to the instruction's end.
// - extension words are fetched at consecutive word addresses after the opcode, up to the 5th word.
// - every sequence except a 16-bit branch contains a word read at the address of the following instruction.
// - a 16-bit branch fetches its extension words, waits one internal state, then reads the target word.
// - an 8-bit branch reads the next word and then the target word with no gap between.
// - a bit test reads extension words, a byte at the operand, then a locked next word, no write.
`timescale 1ns/1ps
`default_nettype none
`include "ibcs_map.svh"

module ibcs_seq
	import ibcs_pkg::*;
#(
	parameter int AW = `IBCS_ADDR_W
) (
	input  wire logic                   clock_i,
	input  wire logic                   nrst_i,
	input  wire logic                   start_i,
	input  wire ibcs_cls_t              op_class_i,
	input  wire logic [`IBCS_IDX_W-1:0] ext_words_i,
	input  wire logic [AW-1:0]          pc_i,
	input  wire logic [AW-1:0]          effective_addr_i,
	input  wire logic [AW-1:0]          target_addr_i,
	input  wire logic                   cyc_ack_i,
	output logic                        cyc_req_o,
	output logic                        cyc_write_o,
	output logic                        cyc_word_o,
	output logic                        cyc_lock_o,
	output logic      [AW-1:0]          cyc_addr_o,
	output logic                        internal_o,
	output logic                        busy_o,
	output logic                        done_o
);

	// =============================================================
	// state
	ibcs_state_t              s_r;
	ibcs_state_t              s_nxt;
	ibcs_st_t                 go;
	logic                     load;
	logic                     finish;
	logic [`IBCS_IDX_W-1:0]   gen_idx;
	logic [AW-1:0]            gen_addr;

	function automatic ibcs_st_t first_after_ext(input ibcs_cls_t c);
		case (c)
			IBCS_CLS_BR_D16:   first_after_ext = IBCS_S_INTERNAL;
			IBCS_CLS_BIT_TEST: first_after_ext = IBCS_S_EA_RD;
			IBCS_CLS_BIT_MOD:  first_after_ext = IBCS_S_EA_RD;
			default:           first_after_ext = IBCS_S_NEXT_RD;
		endcase
	endfunction

	// the index picks an extension word or, past them, the next opcode
	always_comb begin
		if (go == IBCS_S_EXT) begin
			gen_idx = s_nxt.idx;
		end else begin
			gen_idx = `IBCS_IDX_W'(s_nxt.ext + 1'b1);
		end
	end

	ibcs_addr_gen #(
		.AW (AW),
		.IW (`IBCS_IDX_W)
	) u_addr (
		.base_i     (s_nxt.pc),
		.word_idx_i (gen_idx),
		.addr_o     (gen_addr)
	);

	// =============================================================
	// sequencing
	always_comb begin
		s_nxt  = s_r;
		go     = s_r.st;
		load   = 1'b0;
		finish = 1'b0;
		s_nxt.done = 1'b0;
		case (s_r.st)
			IBCS_S_IDLE: begin
				// over-long instructions are refused rather than truncated
				if (start_i && (ext_words_i <= `IBCS_MAX_EXT)) begin
					s_nxt.cls  = op_class_i;
					s_nxt.ext  = ext_words_i;
					s_nxt.pc   = pc_i;
					s_nxt.ea   = effective_addr_i;
					s_nxt.tgt  = target_addr_i;
					s_nxt.idx  = `IBCS_IDX_W'(1);
					s_nxt.busy = 1'b1;
					load = 1'b1;
					if (ext_words_i != '0) begin
						go = IBCS_S_EXT;
					end else begin
						go = first_after_ext(op_class_i);
					end
				end
			end
			IBCS_S_EXT: begin
				if (cyc_ack_i) begin
					load = 1'b1;
					if (s_r.idx == s_r.ext) begin
						go = first_after_ext(s_r.cls);
					end else begin
						go = IBCS_S_EXT;
						s_nxt.idx = `IBCS_IDX_W'(s_r.idx + 1'b1);
					end
				end
			end
			IBCS_S_EA_RD: begin
				if (cyc_ack_i) begin
					load = 1'b1;
					go = IBCS_S_NEXT_RD;
				end
			end
			IBCS_S_NEXT_RD: begin
				if (cyc_ack_i) begin
					if (s_r.cls == IBCS_CLS_BR_D8) begin
						load = 1'b1;
						go = IBCS_S_TGT_RD;
					end else if (s_r.cls == IBCS_CLS_BIT_MOD) begin
						load = 1'b1;
						go = IBCS_S_EA_WR;
					end else begin
						finish = 1'b1;
					end
				end
			end
			IBCS_S_INTERNAL: begin
				if (s_r.cnt >= 2'(`IBCS_INT_STATES - 2'h1)) begin
					load = 1'b1;
					go = IBCS_S_TGT_RD;
				end else begin
					s_nxt.cnt = 2'(s_r.cnt + 2'h1);
				end
			end
			IBCS_S_TGT_RD,
			IBCS_S_EA_WR: begin
				if (cyc_ack_i) begin
					finish = 1'b1;
				end
			end
			default: begin
				finish = 1'b1;
			end
		endcase

		if (load) begin
			s_nxt.st       = go;
			s_nxt.req      = 1'b1;
			s_nxt.wr       = 1'b0;
			s_nxt.word     = 1'b1;
			s_nxt.lock     = 1'b0;
			s_nxt.internal = 1'b0;
			s_nxt.addr     = gen_addr;
			case (go)
				IBCS_S_EA_RD: begin
					s_nxt.word = 1'b0;
					s_nxt.addr = s_nxt.ea;
					s_nxt.lock = (s_nxt.cls == IBCS_CLS_BIT_MOD);
				end
				IBCS_S_NEXT_RD: begin
					// bit operations keep the bus up to their end
					s_nxt.lock = (s_nxt.cls == IBCS_CLS_BIT_TEST)
						|| (s_nxt.cls == IBCS_CLS_BIT_MOD);
				end
				IBCS_S_INTERNAL: begin
					s_nxt.req      = 1'b0;
					s_nxt.internal = 1'b1;
					s_nxt.cnt      = 2'h0;
				end
				IBCS_S_TGT_RD: begin
					s_nxt.addr = s_nxt.tgt;
				end
				IBCS_S_EA_WR: begin
					s_nxt.wr   = 1'b1;
					s_nxt.word = 1'b0;
					s_nxt.addr = s_nxt.ea;
				end
				default: begin
				end
			endcase
		end

		if (finish) begin
			s_nxt.st       = IBCS_S_IDLE;
			s_nxt.req      = 1'b0;
			s_nxt.wr       = 1'b0;
			s_nxt.lock     = 1'b0;
			s_nxt.internal = 1'b0;
			s_nxt.busy     = 1'b0;
			s_nxt.done     = 1'b1;
		end
	end

	// =============================================================
	// registers
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			s_r <= '{st: IBCS_S_IDLE, cls: IBCS_CLS_PLAIN, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign cyc_req_o   = s_r.req;
	assign cyc_write_o = s_r.wr;
	assign cyc_word_o  = s_r.word;
	assign cyc_lock_o  = s_r.lock;
	assign cyc_addr_o  = s_r.addr;
	assign internal_o  = s_r.internal;
	assign busy_o      = s_r.busy;
	assign done_o      = s_r.done;

endmodule // ibcs_seq

`default_nettype wire

//--- tb/ibcs_seq_monitor.sv
// Purpose: port checks of ibcs_seq
// Assumes: pc and target are even
// Notes: bound to every ibcs_seq
`timescale 1ns/1ps
`default_nettype none
`include "ibcs_map.svh"

module ibcs_seq_monitor #(
	parameter int AW = 24
) (
	input wire logic                   clock_i,
	input wire logic                   nrst_i,
	input wire logic                   start_i,
	input wire logic [`IBCS_IDX_W-1:0] ext_words_i,
	input wire logic                   cyc_ack_i,
	input wire logic                   cyc_req_o,
	input wire logic                   cyc_write_o,
	input wire logic                   cyc_word_o,
	input wire logic                   cyc_lock_o,
	input wire logic [AW-1:0]          cyc_addr_o,
	input wire logic                   internal_o,
	input wire logic                   busy_o,
	input wire logic                   done_o
);
	// ========
	// relations
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	chk_cyc_hold: assert property (cyc_req_o && !cyc_ack_i |=> cyc_req_o
		&& $stable(cyc_addr_o) && $stable({cyc_write_o, cyc_word_o, cyc_lock_o}))
		else $error("cycle changed before ack");
	chk_lock_keep: assert property (cyc_req_o && cyc_ack_i && cyc_lock_o
		|=> cyc_req_o || done_o) else $error("bus freed after locked cycle");
	chk_int_gap: assert property (internal_o |-> !cyc_req_o
		##1 cyc_req_o && !internal_o) else $error("internal state not one cycle");
	chk_int_lead: assert property ($rose(internal_o) |-> $past(cyc_ack_i)
		&& $past(cyc_word_o)) else $error("internal state without word fetch");
	chk_write_byte: assert property (cyc_req_o && cyc_write_o |-> !cyc_word_o
		&& !cyc_lock_o) else $error("bad write kind");
	chk_done_pulse: assert property (done_o |-> !busy_o && $past(cyc_ack_i)
		##1 !done_o) else $error("bad done pulse");
	chk_start_req: assert property (start_i && !busy_o && ext_words_i <= 3'h4
		|=> busy_o && cyc_req_o) else $error("start not answered");
	chk_word_even: assert property (cyc_req_o && cyc_word_o |-> !cyc_addr_o[0])
		else $error("odd word address");
endmodule // ibcs_seq_monitor

bind ibcs_seq ibcs_seq_monitor #(.AW(AW)) u_mon (.clock_i(clock_i), .nrst_i(nrst_i),
	.start_i(start_i), .ext_words_i(ext_words_i), .cyc_ack_i(cyc_ack_i),
	.cyc_req_o(cyc_req_o), .cyc_write_o(cyc_write_o), .cyc_word_o(cyc_word_o),
	.cyc_lock_o(cyc_lock_o), .cyc_addr_o(cyc_addr_o), .internal_o(internal_o),
	.busy_o(busy_o), .done_o(done_o));
`default_nettype wire

//--- tb/ibcs_mem_model.sv
// Purpose: memory side acking cycles
// Assumes: one ack pulse per cycle
// Notes: random wait, prompt or slow
`timescale 1ns/1ps
`default_nettype none

module ibcs_mem_model (
	input  wire logic clock_i,
	input  wire logic nrst_i,
	input  wire logic cyc_req_i,
	output var logic  cyc_ack_o
);
	// ========
	// acknowledge
	initial cyc_ack_o = 1'b0;
	// ack drops after each pulse so one pulse never covers two cycles
	always @(posedge clock_i) begin
		cyc_ack_o <= nrst_i && cyc_req_i && !cyc_ack_o && ($urandom_range(1) == 0);
	end
endmodule // ibcs_mem_model
`default_nettype wire

//--- tb/tb_instruction_bus_cycle_sequencer.sv
// Purpose: self-checking bench of ibcs_seq
// Assumes: memory model acks at random
// Notes: queue model of each class
`timescale 1ns/1ps
`default_nettype none

module tb_instruction_bus_cycle_sequencer
	import ibcs_pkg::*;
;
	// ========
	// bench
	logic        clock_i = 1'b0, nrst_i = 1'b0, start_i = 1'b0;
	ibcs_cls_t   cls     = IBCS_CLS_PLAIN;
	logic [2:0]  ext     = 3'h0;
	logic [23:0] pc = 24'h0, ea = 24'h0, tgt = 24'h0, addr;
	logic        ack, req, wr, wd, lk, intl, busy, done;
	logic [26:0] exp_q[$];
	int          bad_count = 0, samples_checked = 0, k, int_seen = 0;

	always #10 clock_i = ~clock_i;
	ibcs_seq dut (.clock_i(clock_i), .nrst_i(nrst_i), .start_i(start_i), .op_class_i(cls),
		.ext_words_i(ext), .pc_i(pc), .effective_addr_i(ea), .target_addr_i(tgt),
		.cyc_ack_i(ack), .cyc_req_o(req), .cyc_write_o(wr), .cyc_word_o(wd), .cyc_lock_o(lk),
		.cyc_addr_o(addr), .internal_o(intl), .busy_o(busy), .done_o(done));
	ibcs_mem_model mem (.clock_i(clock_i), .nrst_i(nrst_i), .cyc_req_i(req), .cyc_ack_o(ack));

	task automatic conclude();
		if (bad_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check_cyc(input logic [26:0] got);
		logic [26:0] e;
		e = (exp_q.size() > 0) ? exp_q.pop_front() : 27'hX;
		samples_checked++;
		if (got !== e) begin
			bad_count++;
			$display("ERROR %0t cycle %h expected %h", $time, got, e);
		end
	endtask

	task automatic check_flag(input logic got, input logic e);
		samples_checked++;
		if (got !== e) begin
			bad_count++;
			$display("ERROR %0t flag %b expected %b", $time, got, e);
		end
	endtask

	// entries are {write, word, lock, address}
	always @(posedge clock_i) begin
		if (nrst_i && req && ack) begin
			check_cyc({wr, wd, lk, addr});
		end
		// internal states are counted here and judged per instruction
		if (nrst_i && intl) begin
			int_seen++;
		end
	end

	task automatic run(input ibcs_cls_t c, input logic [2:0] n);
		logic [23:0] p, e, t, nx;
		int          i, i0;
		p  = 24'($urandom) & 24'hFFFFFE;
		e  = 24'($urandom);
		t  = 24'($urandom) & 24'hFFFFFE;
		nx = p + 24'(2 * (n + 1));
		for (i = 1; i <= n; i++) begin
			exp_q.push_back({3'b010, p + 24'(2 * i)});
		end
		case (c)
			IBCS_CLS_PLAIN: begin
				exp_q.push_back({3'b010, nx});
			end
			IBCS_CLS_BR_D8: begin
				exp_q.push_back({3'b010, nx});
				exp_q.push_back({3'b010, t});
			end
			IBCS_CLS_BR_D16: begin
				exp_q.push_back({3'b010, t});
			end
			IBCS_CLS_BIT_TEST: begin
				exp_q.push_back({3'b000, e});
				exp_q.push_back({3'b011, nx});
			end
			default: begin
				exp_q.push_back({3'b001, e});
				exp_q.push_back({3'b011, nx});
				exp_q.push_back({3'b100, e});
			end
		endcase
		i0 = int_seen;
		@(posedge clock_i);
		cls     <= c;
		ext     <= n;
		pc      <= p;
		ea      <= e;
		tgt     <= t;
		start_i <= 1'b1;
		// a second start while busy, with other inputs, must change nothing
		@(posedge clock_i);
		cls <= IBCS_CLS_BIT_MOD;
		pc  <= ~p;
		@(posedge clock_i);
		start_i <= 1'b0;
		i = 0;
		do begin
			@(negedge clock_i);
			i++;
			if (i == 1) begin
				check_flag(busy, 1'b1);
			end
		end while (done !== 1'b1 && i < 200);
		check_flag(done === 1'b1 && exp_q.size() == 0, 1'b1);
		check_flag((int_seen - i0) == ((c == IBCS_CLS_BR_D16) ? 1 : 0), 1'b1);
	endtask

	initial begin
		void'($urandom(78892));
		repeat (2) @(posedge clock_i);
		nrst_i <= 1'b1;
		@(posedge clock_i);
		{ext, start_i} <= {3'h5, 1'b1};
		@(posedge clock_i);
		start_i <= 1'b0;
		@(negedge clock_i);
		check_flag(busy, 1'b0);
		for (k = 0; k < 60; k++) begin
			run(ibcs_cls_t'(k % 5), (k % 5 == 2) ? 3'h1 + 3'($urandom_range(3)) : 3'($urandom_range(4)));
		end
		// reset in mid-instruction drops the rest of it and clears every output
		exp_q.push_back({3'b010, 24'h000102});
		exp_q.push_back({3'b010, 24'h000104});
		exp_q.push_back({3'b001, 24'h000155});
		@(posedge clock_i);
		cls     <= IBCS_CLS_BIT_MOD;
		ext     <= 3'h2;
		pc      <= 24'h000100;
		ea      <= 24'h000155;
		start_i <= 1'b1;
		@(posedge clock_i);
		start_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		nrst_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		@(negedge clock_i);
		check_flag(|{req, wr, wd, lk, addr, intl, busy, done}, 1'b0);
		exp_q.delete();
		@(posedge clock_i);
		nrst_i <= 1'b1;
		run(IBCS_CLS_BIT_MOD, 3'h1);
		conclude();
	end

	// 60 instructions take well under 3000 cycles; 20000 means a hang
	initial begin
		#400000;
		bad_count++;
		conclude();
	end
endmodule // tb_instruction_bus_cycle_sequencer
`default_nettype wire
